// ===== hdl/msem_pkg.sv
package msem_pkg;

    // ----------------------------------------------------------------
    // Access spaces and control profiles
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SP_COIL,
        SP_DISCRETE,
        SP_INPUT,
        SP_HOLDING
    } msem_space_type;

    typedef enum logic {
        PROF_FIRST,
        PROF_SECOND
    } msem_profile_type;

    // ----------------------------------------------------------------
    // Discrete input positions, first profile
    // ----------------------------------------------------------------
    localparam int P1_SWITCHED_ON_READY = 0;
    localparam int P1_RUN_READY = 1;
    localparam int P1_REFERENCE_READY = 2;
    localparam int P1_ITEM_A = 3;
    localparam int P1_COAST_STOP = 4;
    localparam int P1_QUICK_STOP = 5;
    localparam int P1_SWITCH_ON_INHIBITED = 6;
    localparam int P1_ALARM = 7;
    localparam int P1_SETPOINT_REACHED = 8;
    localparam int P1_REMOTE = 9;
    localparam int P1_LIMIT_EXCEEDED = 10;
    localparam int P1_SPARE_BASE = 11;

    // ----------------------------------------------------------------
    // Discrete input positions, second profile
    // ----------------------------------------------------------------
    localparam int P2_READY = 0;
    localparam int P2_ENABLED = 1;
    localparam int P2_RUNNING = 3;
    localparam int P2_SPEED_IS_ZERO = 4;
    localparam int P2_SETPOINT_REACHED = 7;
    localparam int P2_LIMIT = 8;
    localparam int P2_ITEM_B = 9;
    localparam int P2_KEYPAD_LOCAL = 12;
    localparam int P2_BUS_LOCAL = 13;
    localparam int P2_SECOND_EXTERNAL_ACTIVE = 14;
    localparam int P2_FAULT = 15;
    localparam int P2_ALARM = 16;
    localparam int P2_SPARE_BASE = 22;
    localparam int P2_CONTROL_REQUESTED = 26;

    // ----------------------------------------------------------------
    // Positions shared by both profiles
    // ----------------------------------------------------------------
    localparam int POS_DIGITAL_INPUT_BASE = 32;
    localparam int DIGITAL_INPUT_COUNT = 4;
    localparam int POS_DIGITAL_OUTPUT_ONE = 36;
    localparam int DIGITAL_OUTPUT_ONE_BIT = 4;
    localparam int DI_COUNT = 37;
    localparam logic [15:0] DI_LAST_ADDR = 16'h0024;

    // ----------------------------------------------------------------
    // Holding register references
    // ----------------------------------------------------------------
    localparam logic [15:0] REF_ERROR_CLEAR_REQUEST = 16'h0059;
    localparam logic [15:0] REF_FAILED_FUNCTION_CODE = 16'h005A;
    localparam logic [15:0] REF_FAILURE_REASON_CODE = 16'h005B;
    localparam logic [15:0] REF_LAST_FAILED_ADDRESS = 16'h005C;
    localparam logic [15:0] REF_LAST_GOOD_WRITE_ADDRESS = 16'h005D;
    localparam logic [15:0] REF_LAST_GOOD_READ_ADDRESS = 16'h005E;
    localparam logic [15:0] CLEAR_COMMAND = 16'h0001;
    localparam logic [15:0] ERR_REG_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Exception and failure reason codes
    // ----------------------------------------------------------------
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_DEVICE_FAILURE = 8'h04;
    localparam logic [7:0] EC_NONE = 8'h00;
    localparam logic [7:0] EC_LIMIT_EXCEEDED = 8'h02;
    localparam logic [7:0] EC_BAD_INDEX = 8'h03;
    localparam logic [7:0] EC_BAD_DATA_TYPE = 8'h05;
    localparam logic [7:0] EC_GENERAL = 8'h65;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic switched_on_ready;
        logic run_ready;
        logic reference_ready;
        logic item_a;
        logic coast_stop_status;
        logic quick_stop_status;
        logic switch_on_inhibited;
        logic alarm;
        logic setpoint_reached;
        logic remote;
        logic limit_exceeded;
        logic [3:0] spare_status;
        logic ready;
        logic enabled;
        logic running;
        logic speed_is_zero;
        logic limit;
        logic item_b;
        logic keypad_local;
        logic bus_local;
        logic second_external_active;
        logic fault;
        logic control_requested;
    } msem_status_type;

    typedef struct packed {
        logic valid;
        logic write;
        msem_space_type space;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [7:0] func;
    } msem_access_type;

    typedef struct packed {
        logic valid;
        logic ok;
        logic write;
        logic [15:0] addr;
        logic [7:0] func;
        logic [7:0] exc;
        logic [7:0] err_code;
    } msem_result_type;

endpackage

// ===== hdl/msem_di_image.sv
module msem_di_image import msem_pkg::*; #(
    parameter int N = DI_COUNT
) (
    // Selection and sources
    input wire msem_profile_type profile_i,
    input wire msem_status_type status_i,
    input wire logic [15:0] di_delayed_word_i,
    input wire logic [15:0] do_delayed_word_i,
    // Discrete input image
    output logic [N-1:0] image_o
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (N < DI_COUNT) begin : g_size_check
        $error("msem_di_image: N too small for the discrete input map");
    end

    // ----------------------------------------------------------------
    // Position map; unassigned positions stay zero
    // ----------------------------------------------------------------
    always_comb begin
        image_o = '0;
        if (profile_i == PROF_FIRST) begin
            image_o[P1_SWITCHED_ON_READY] = status_i.switched_on_ready;
            image_o[P1_RUN_READY] = status_i.run_ready;
            image_o[P1_REFERENCE_READY] = status_i.reference_ready;
            image_o[P1_ITEM_A] = status_i.item_a;
            image_o[P1_COAST_STOP] = status_i.coast_stop_status;
            image_o[P1_QUICK_STOP] = status_i.quick_stop_status;
            image_o[P1_SWITCH_ON_INHIBITED] = status_i.switch_on_inhibited;
            image_o[P1_ALARM] = status_i.alarm;
            image_o[P1_SETPOINT_REACHED] = status_i.setpoint_reached;
            image_o[P1_REMOTE] = status_i.remote;
            image_o[P1_LIMIT_EXCEEDED] = status_i.limit_exceeded;
            image_o[P1_SPARE_BASE +: 4] = status_i.spare_status;
        end else begin
            image_o[P2_READY] = status_i.ready;
            image_o[P2_ENABLED] = status_i.enabled;
            image_o[P2_RUNNING] = status_i.running;
            image_o[P2_SPEED_IS_ZERO] = status_i.speed_is_zero;
            image_o[P2_SETPOINT_REACHED] = status_i.setpoint_reached;
            image_o[P2_LIMIT] = status_i.limit;
            image_o[P2_ITEM_B] = status_i.item_b;
            image_o[P2_KEYPAD_LOCAL] = status_i.keypad_local;
            image_o[P2_BUS_LOCAL] = status_i.bus_local;
            image_o[P2_SECOND_EXTERNAL_ACTIVE] = status_i.second_external_active;
            image_o[P2_FAULT] = status_i.fault;
            image_o[P2_ALARM] = status_i.alarm;
            image_o[P2_SPARE_BASE +: 4] = status_i.spare_status;
            image_o[P2_CONTROL_REQUESTED] = status_i.control_requested;
        end
        // Shared tail of the map, same in both profiles
        image_o[POS_DIGITAL_INPUT_BASE +: DIGITAL_INPUT_COUNT] =
            di_delayed_word_i[DIGITAL_INPUT_COUNT-1:0];
        image_o[POS_DIGITAL_OUTPUT_ONE] = do_delayed_word_i[DIGITAL_OUTPUT_ONE_BIT];
    end

endmodule

// ===== hdl/msem_top.sv
// How it works
// - Discrete inputs are single read-only bits; client writes never change them.
// - Drive status word bits are presented in the discrete input space.
// - Reference numbers equal the address carried in the request.
// - First profile maps eleven status bits to 0..10, spare bits to 11..14.
// - Second profile maps its status bits to listed positions up to 26.
// - Positions 32..35 show delayed digital inputs one to four, word bits 0..3.
// - Position 36 shows delayed digital output one, output word bit 4.
// - Error registers describe the latest query; success clears references 90..92.
// - Writing 1 at reference 89 clears error registers; writing 0 is recorded as a successful write to 89.
// - Reference 90 holds the function code of the failed query.
// - Reference 91 loads only when a query ends with exception 04h.
// - Reason codes are 00h, 02h, 03h, 05h and 65h.
// - Reference 92 holds the last address whose read or write failed.
// - Reference 93 holds the last address written successfully.
// - Reference 94 holds the last address read successfully.
// - Unrecoverable errors during an action answer with exception 04h.
module msem_top import msem_pkg::*; #(
    parameter int N_DI = DI_COUNT
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Drive state sources
    input wire msem_profile_type profile_i,
    input wire msem_status_type status_i,
    input wire logic [15:0] di_delayed_word_i,
    input wire logic [15:0] do_delayed_word_i,
    // Access from the transport for spaces held here
    input wire msem_access_type access_i,
    // Outcome of queries handled elsewhere in the server
    input wire msem_result_type result_i,
    // Answer to an access
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o,
    output logic [7:0] rsp_exc_o
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (N_DI != DI_COUNT) begin : g_size_check
        $error("msem_top: N_DI must match the discrete input map");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [N_DI-1:0] di_image;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic [15:0] rsp_data_reg;
    logic [15:0] rsp_data_next;
    logic [7:0] rsp_exc_reg;
    logic [7:0] rsp_exc_next;
    msem_result_type own_res;
    msem_result_type sel_res;
    logic clear_hit;
    logic [15:0] failed_function_code_reg;
    logic [15:0] failed_function_code_next;
    logic [15:0] failure_reason_code_reg;
    logic [15:0] failure_reason_code_next;
    logic [15:0] last_failed_address_reg;
    logic [15:0] last_failed_address_next;
    logic [15:0] last_good_write_address_reg;
    logic [15:0] last_good_write_address_next;
    logic [15:0] last_good_read_address_reg;
    logic [15:0] last_good_read_address_next;

    // ----------------------------------------------------------------
    // Discrete input image
    // ----------------------------------------------------------------
    // Built combinationally so a read sees the status of its own cycle
    msem_di_image #(
        .N(N_DI)
    ) u_image (
        .profile_i(profile_i),
        .status_i(status_i),
        .di_delayed_word_i(di_delayed_word_i),
        .do_delayed_word_i(do_delayed_word_i),
        .image_o(di_image)
    );

    // ----------------------------------------------------------------
    // Access decode and answer
    // ----------------------------------------------------------------
    // The address is used as the position directly, no offset of one
    always_comb begin
        rsp_valid_next = access_i.valid;
        rsp_data_next = 16'h0000;
        rsp_exc_next = EXC_NONE;
        clear_hit = 1'b0;
        if (access_i.valid) begin
            unique case (access_i.space)
                SP_DISCRETE: begin
                    if (access_i.write) begin
                        rsp_exc_next = EXC_ILLEGAL_FUNCTION;
                    end else if (access_i.addr <= DI_LAST_ADDR) begin
                        rsp_data_next = {15'h0000, di_image[access_i.addr[5:0]]};
                    end else begin
                        rsp_exc_next = EXC_ILLEGAL_ADDRESS;
                    end
                end
                SP_HOLDING: begin
                    if (access_i.write) begin
                        if (access_i.addr == REF_ERROR_CLEAR_REQUEST) begin
                            clear_hit = (access_i.wdata == CLEAR_COMMAND);
                        end else begin
                            rsp_exc_next = EXC_ILLEGAL_ADDRESS;
                        end
                    end else begin
                        unique case (access_i.addr)
                            REF_FAILED_FUNCTION_CODE: rsp_data_next = failed_function_code_reg;
                            REF_FAILURE_REASON_CODE: rsp_data_next = failure_reason_code_reg;
                            REF_LAST_FAILED_ADDRESS: rsp_data_next = last_failed_address_reg;
                            REF_LAST_GOOD_WRITE_ADDRESS: begin
                                rsp_data_next = last_good_write_address_reg;
                            end
                            REF_LAST_GOOD_READ_ADDRESS: begin
                                rsp_data_next = last_good_read_address_reg;
                            end
                            default: rsp_exc_next = EXC_ILLEGAL_ADDRESS;
                        endcase
                    end
                end
                default: rsp_exc_next = EXC_ILLEGAL_ADDRESS;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 16'h0000;
            rsp_exc_reg <= EXC_NONE;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
            rsp_exc_reg <= rsp_exc_next;
        end
    end

    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_data_o = rsp_data_reg;
    assign rsp_exc_o = rsp_exc_reg;

    // ----------------------------------------------------------------
    // Query outcome selection
    // ----------------------------------------------------------------
    // Only one outcome is recorded per cycle; the report on result_i wins
    // because it describes a query the client issued more recently
    always_comb begin
        own_res.valid = access_i.valid;
        own_res.ok = (rsp_exc_next == EXC_NONE);
        own_res.write = access_i.write;
        own_res.addr = access_i.addr;
        own_res.func = access_i.func;
        own_res.exc = rsp_exc_next;
        own_res.err_code = EC_NONE;
        sel_res = result_i.valid ? result_i : own_res;
    end

    // ----------------------------------------------------------------
    // Error registers
    // ----------------------------------------------------------------
    always_comb begin
        failed_function_code_next = failed_function_code_reg;
        failure_reason_code_next = failure_reason_code_reg;
        last_failed_address_next = last_failed_address_reg;
        last_good_write_address_next = last_good_write_address_reg;
        last_good_read_address_next = last_good_read_address_reg;
        if (sel_res.valid) begin
            if (sel_res.ok) begin
                failed_function_code_next = ERR_REG_RESET;
                failure_reason_code_next = ERR_REG_RESET;
                last_failed_address_next = ERR_REG_RESET;
                if (sel_res.write) begin
                    last_good_write_address_next = sel_res.addr;
                end else begin
                    last_good_read_address_next = sel_res.addr;
                end
            end else begin
                failed_function_code_next = {8'h00, sel_res.func};
                last_failed_address_next = sel_res.addr;
                if (sel_res.exc == EXC_DEVICE_FAILURE) begin
                    failure_reason_code_next = {8'h00, sel_res.err_code};
                end
            end
        end
        // The clear request overrides whatever outcome lands alongside it
        if (clear_hit) begin
            failed_function_code_next = ERR_REG_RESET;
            failure_reason_code_next = ERR_REG_RESET;
            last_failed_address_next = ERR_REG_RESET;
            last_good_write_address_next = ERR_REG_RESET;
            last_good_read_address_next = ERR_REG_RESET;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            failed_function_code_reg <= ERR_REG_RESET;
            failure_reason_code_reg <= ERR_REG_RESET;
            last_failed_address_reg <= ERR_REG_RESET;
            last_good_write_address_reg <= ERR_REG_RESET;
            last_good_read_address_reg <= ERR_REG_RESET;
        end else begin
            failed_function_code_reg <= failed_function_code_next;
            failure_reason_code_reg <= failure_reason_code_next;
            last_failed_address_reg <= last_failed_address_next;
            last_good_write_address_reg <= last_good_write_address_next;
            last_good_read_address_reg <= last_good_read_address_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_di_read(logic [15:0] a);
        access_i.valid && !access_i.write && access_i.space == SP_DISCRETE
            && !result_i.valid && access_i.addr == a;
    endsequence

    sequence s_ext_fail;
        result_i.valid && !result_i.ok;
    endsequence

    sequence s_ext_ok;
        result_i.valid && result_i.ok;
    endsequence

    property p_di_write_refused;
        (access_i.valid && access_i.write && access_i.space == SP_DISCRETE && !result_i.valid)
            |=> rsp_valid_o && rsp_exc_o == EXC_ILLEGAL_FUNCTION
                && $stable(last_good_write_address_reg);
    endproperty
    a_di_write_refused: assert property (p_di_write_refused)
        else $error("discrete write not refused");

    property p_first_profile_alarm;
        (s_di_read(16'h0007) and profile_i == PROF_FIRST)
            |=> rsp_data_o == {15'h0000, $past(status_i.alarm)};
    endproperty
    a_first_profile_alarm: assert property (p_first_profile_alarm)
        else $error("first profile position 7 wrong");

    property p_second_profile_request;
        (s_di_read(16'h001A) and profile_i == PROF_SECOND)
            |=> rsp_data_o == {15'h0000, $past(status_i.control_requested)};
    endproperty
    a_second_profile_request: assert property (p_second_profile_request)
        else $error("second profile position 26 wrong");

    property p_digital_input_four;
        s_di_read(16'h0023) |=> rsp_data_o == {15'h0000, $past(di_delayed_word_i[3])};
    endproperty
    a_digital_input_four: assert property (p_digital_input_four)
        else $error("position 35 does not follow input word bit 3");

    property p_digital_output_one;
        s_di_read(16'h0024) |=> rsp_data_o == {15'h0000, $past(do_delayed_word_i[4])};
    endproperty
    a_digital_output_one: assert property (p_digital_output_one)
        else $error("position 36 does not follow output word bit 4");

    property p_reserved_zero;
        (s_di_read(16'h0002) and profile_i == PROF_SECOND)
            |=> rsp_exc_o == EXC_NONE && rsp_data_o == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved position not zero");

    property p_success_clears;
        (s_ext_ok and !clear_hit) |=> failed_function_code_reg == ERR_REG_RESET
            && last_failed_address_reg == ERR_REG_RESET
            && failure_reason_code_reg == ERR_REG_RESET;
    endproperty
    a_success_clears: assert property (p_success_clears)
        else $error("success did not clear error registers");

    property p_clear_zero_ignored;
        (access_i.valid && access_i.write && access_i.space == SP_HOLDING
            && access_i.addr == REF_ERROR_CLEAR_REQUEST && access_i.wdata == 16'h0000
            && !result_i.valid)
            |=> $stable(last_good_read_address_reg)
                && last_good_write_address_reg == REF_ERROR_CLEAR_REQUEST
                && rsp_exc_o == EXC_NONE;
    endproperty
    a_clear_zero_ignored: assert property (p_clear_zero_ignored)
        else $error("writing zero to clear request cleared registers");

    property p_failure_recorded;
        (s_ext_fail and !clear_hit) |=> failed_function_code_reg == {8'h00, $past(result_i.func)}
            && last_failed_address_reg == $past(result_i.addr);
    endproperty
    a_failure_recorded: assert property (p_failure_recorded)
        else $error("failure not recorded");

    property p_reason_only_on_device_failure;
        (s_ext_fail and result_i.exc != EXC_DEVICE_FAILURE and !clear_hit)
            |=> $stable(failure_reason_code_reg);
    endproperty
    a_reason_only_on_device_failure: assert property (p_reason_only_on_device_failure)
        else $error("reason code loaded without exception 04h");

    property p_good_read_recorded;
        (s_ext_ok and !result_i.write and !clear_hit)
            |=> last_good_read_address_reg == $past(result_i.addr)
                && $stable(last_good_write_address_reg);
    endproperty
    a_good_read_recorded: assert property (p_good_read_recorded)
        else $error("last good read address wrong");

endmodule

// ===== verif/msem_client_model.sv
module msem_client_model import msem_pkg::*; (
    // Clock
    input wire logic sys_clk_i,
    // Request to the server
    output msem_access_type access_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle until the first call
    initial access_o = '0;
    // One-cycle strobe; fields are scrambled after release so nobody reads stale values
    task automatic acc(input logic w, input msem_space_type s, input logic [15:0] a,
        input logic [15:0] d);
        @(negedge sys_clk_i);
        access_o = '{1'b1, w, s, a, d, w ? 8'h06 : 8'h03};
        @(negedge sys_clk_i);
        access_o = {1'b0, ~access_o[42:0]};
    endtask
endmodule

// ===== verif/msem_top_tb.sv
module msem_top_tb import msem_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    msem_profile_type prof = PROF_FIRST;
    msem_status_type st = '0;
    logic [15:0] dw = 16'h0000;
    logic [15:0] ow = 16'h0000;
    msem_access_type acc;
    msem_result_type res_v = '0;
    logic rsp_valid_o;
    logic [15:0] rsp_data_o;
    logic [7:0] rsp_exc_o;
    logic [23:0] exp_q[$];
    logic [15:0] tbl[3] = '{16'h0003, 16'h0002, 16'h0010};
    logic [31:0] rng = 32'h00000046;
    int error_cnt = 0;
    int total_checks = 0;
    // Clock, 4 ns period
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    msem_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .profile_i(prof), .status_i(st),
        .di_delayed_word_i(dw), .do_delayed_word_i(ow), .access_i(acc), .result_i(res_v),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_exc_o(rsp_exc_o));
    msem_client_model cli (.sys_clk_i(sys_clk_i), .access_o(acc));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic fail(input string m);
        error_cnt++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0 && exp_q.size() == 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Note the answer first, then let the client send the access
    task automatic go(input logic w, input msem_space_type s, input logic [15:0] a,
        input logic [15:0] d, input logic [7:0] e, input logic [15:0] x);
        exp_q.push_back({e, x});
        cli.acc(w, s, a, d);
    endtask
    task automatic hr(input logic [15:0] a, input logic [15:0] x);
        go(1'b0, SP_HOLDING, a, 16'h0000, EXC_NONE, x);
    endtask
    // Outcome of a query served elsewhere; w tells a write from a read
    task automatic res(input logic ok, input logic w, input logic [15:0] a,
        input logic [7:0] e, input logic [7:0] c);
        @(negedge sys_clk_i);
        res_v = '{1'b1, ok, w, a, 8'h03, e, c};
        @(negedge sys_clk_i);
        res_v.valid = 1'b0;
    endtask
    // Compare each answer with the oldest note
    always @(negedge sys_clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            total_checks++;
            if (exp_q.size() == 0 || {rsp_exc_o, rsp_data_o} !== exp_q.pop_front())
                fail("answer mismatch");
        end
    end
    // Cut a hung run short
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        fail("run did not finish");
        print_verdict();
    end
    // Main sequence: discrete map per profile, then error register history
    initial begin
        repeat (10) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        for (int p = 0; p < 2; p++) begin
            rng = xs(rng);
            st = rng[25:0];
            {ow, dw} = xs(rng);
            prof = msem_profile_type'(p[0]);
            for (int i = 0; i < 5; i++)
                go(1'b0, SP_DISCRETE, 16'(32 + i), 16'h0000, EXC_NONE,
                    {15'h0000, i < 4 ? dw[i] : ow[4]});
            go(1'b0, SP_DISCRETE, p ? 16'h001A : 16'h0007, 16'h0000, EXC_NONE,
                {15'h0000, p ? st.control_requested : st.alarm});
            go(1'b0, SP_DISCRETE, 16'h0002, 16'h0000, EXC_NONE,
                {15'h0000, p ? 1'b0 : st.reference_ready});
            go(1'b0, SP_DISCRETE, 16'h0003, 16'h0000, EXC_NONE,
                {15'h0000, p ? st.running : st.item_a});
            go(1'b0, SP_DISCRETE, p ? 16'h0016 : 16'h000B, 16'h0000, EXC_NONE,
                {15'h0000, st.spare_status[0]});
            hr(16'h005E, p ? 16'h0016 : 16'h000B);
            go(1'b1, SP_DISCRETE, 16'h0011, 16'h0001, EXC_ILLEGAL_FUNCTION, 16'h0000);
        end
        go(1'b0, SP_DISCRETE, 16'h0025, 16'h0000, EXC_ILLEGAL_ADDRESS, 16'h0000);
        hr(16'h005C, 16'h0025);
        hr(16'h005A, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            res(1'b0, 1'b0, 16'h0010, EXC_DEVICE_FAILURE, EC_LIMIT_EXCEEDED);
            hr(16'h005A + 16'(i), tbl[i]);
        end
        res(1'b0, 1'b0, 16'h0010, EXC_DEVICE_FAILURE, EC_BAD_DATA_TYPE);
        res(1'b0, 1'b0, 16'h0020, EXC_ILLEGAL_ADDRESS, EC_GENERAL);
        hr(16'h005B, 16'h0005);
        res(1'b1, 1'b1, 16'h0030, EXC_NONE, EC_NONE);
        hr(16'h005D, 16'h0030);
        go(1'b1, SP_HOLDING, 16'h0059, 16'h0000, EXC_NONE, 16'h0000);
        hr(16'h005D, 16'h0059);
        go(1'b1, SP_HOLDING, 16'h0059, 16'h0001, EXC_NONE, 16'h0000);
        hr(16'h005D, 16'h0000);
        hr(16'h005E, 16'h005D);
        res(1'b1, 1'b0, 16'h0040, EXC_NONE, EC_NONE);
        hr(16'h005E, 16'h0040);
        go(1'b0, SP_HOLDING, 16'h0059, 16'h0000, EXC_ILLEGAL_ADDRESS, 16'h0000);
        repeat (3) @(negedge sys_clk_i);
        print_verdict();
    end
endmodule
